// ---- common/glch_pkg.sv ----
// Package for the pin and indicator command handler.
// Assumes one clock domain and commands delivered as whole parsed frames.
package glch_pkg;

    // ------------------------------------------------------------------
    // Command opcodes (internal to the block)
    // ------------------------------------------------------------------
    localparam logic [1:0] CMD_LED_SETUP = 2'h0;
    localparam logic [1:0] CMD_PIN_SETUP = 2'h1;
    localparam logic [1:0] CMD_PIN_WRITE = 2'h2;
    localparam logic [1:0] CMD_PIN_READ  = 2'h3;

    // ------------------------------------------------------------------
    // Argument byte counts
    // ------------------------------------------------------------------
    localparam logic [3:0] LEN_LED_SETUP = 4'h0a;
    localparam logic [3:0] LEN_PIN_SETUP = 4'h2;
    localparam logic [3:0] LEN_PIN_WRITE = 4'h2;
    localparam logic [3:0] LEN_PIN_READ  = 4'h1;

    // ------------------------------------------------------------------
    // Response codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RSP_OK        = 8'h00;
    localparam logic [7:0] RSP_SHORT     = 8'h01;
    localparam logic [7:0] RSP_LONG      = 8'h02;
    localparam logic [7:0] RSP_NOT_PIN   = 8'h08;
    localparam logic [7:0] RSP_IN_USE    = 8'h09;
    localparam logic [7:0] RSP_BAD_CFG   = 8'h12;
    localparam logic [7:0] RSP_NOT_OUT   = 8'h16;
    localparam logic [7:0] RSP_UNCONF    = 8'h17;

    // ------------------------------------------------------------------
    // Configuration byte fields
    // ------------------------------------------------------------------
    localparam int         CFG_DIR_BIT   = 0;
    localparam int         CFG_INIT_BIT  = 1;
    localparam logic [7:0] CFG_VALID_MSK = 8'h03;

    // ------------------------------------------------------------------
    // Indicator index and timing
    // ------------------------------------------------------------------
    localparam int         NUM_IND       = 5;
    localparam int         IND_NET_RX    = 0;
    localparam int         IND_NET_TX    = 1;
    localparam int         IND_SER_RX    = 2;
    localparam int         IND_SER_TX    = 3;
    localparam int         IND_ACTIVE    = 4;
    localparam int         CLK_MHZ       = 100;
    localparam int         LED_HOLD_US   = 20000;
    localparam int         LED_HOLD_CYC  = LED_HOLD_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OWN_UNUSED,
        OWN_GP_IN,
        OWN_GP_OUT,
        OWN_LED,
        OWN_IFACE
    } glch_own_t;

endpackage : glch_pkg

// ---- logic/glch_led_stretch.sv ----
// Pulse stretcher for one indicator output.
// Assumes events are single-cycle pulses in the system clock domain.
`timescale 1ns/100ps
module glch_led_stretch #(
    parameter int HOLD_CYC = glch_pkg::LED_HOLD_CYC
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_enable,
    input  wire logic i_event,
    output logic      o_led
);
    typedef struct packed
    {
        logic [31:0] cnt;
        logic        led;
    } glch_str_t;

    glch_str_t s_q;
    glch_str_t s_d;

    // RL21 hold minimum time
    always_comb
    begin
        s_d = s_q;
        if (!i_enable)
        begin
            s_d.cnt = '0;
            s_d.led = 1'b0;
        end
        else if (i_event)
        begin
            s_d.cnt = 32'(HOLD_CYC);
            s_d.led = 1'b1;
        end
        else if (s_q.cnt > 32'h0000_0001)
        begin
            s_d.cnt = s_q.cnt - 32'h0000_0001;
        end
        else
        begin
            s_d.cnt = '0;
            s_d.led = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_led = s_q.led;
endmodule : glch_led_stretch

// ---- logic/glch_cmd_handler.sv ----
// Pin and indicator command handler of the serial command link.
// Assumes an upstream parser hands over whole frames in one strobe
// and that pin levels are synchronous.
//
// Overview of operation
// RL1 - LED setup: five pin/config byte pairs
// RL2 - Pin number zero disables that indicator
// RL3 - Initial-level bit ignored for indicator pins
// RL4 - Indicator pin must be unused and output
// RL5 - Indicators show traffic and power state
// RL6 - Non-LED-capable pin answers code 8
// RL7 - Pin already owned answers code 9
// RL8 - Pin setup: pin, config; bad config 18
// RL9 - Success code only when acknowledges enabled; pin reads send it regardless
// RL10 - Too short code 1, too long 2
// RL11 - Pin setup only on unused pins
// RL12 - Non-general pin setup answers code 8
// RL13 - Pin write: pin and value 0/1
// RL14 - Write only general outputs, else 22
// RL15 - Write/read non-general pin answers 8
// RL16 - Pin read carries one pin byte
// RL17 - Read any configured or owned pin
// RL18 - Read success: code 0, then level
// RL19 - Read of unused pin answers 23
// RL20 - Per-pin ownership checked before every action
// RL21 - Indicator held on a minimum time
`timescale 1ns/100ps
module glch_cmd_handler #(
    parameter int         NUM_PINS = 32,
    parameter int         HOLD_CYC = glch_pkg::LED_HOLD_CYC,
    parameter logic [31:0] GP_CAPABLE  = 32'hffff_fffe,
    parameter logic [31:0] LED_CAPABLE = 32'hffff_fffe
) (
    input  wire logic                i_clock,
    input  wire logic                i_rst_n,
    input  wire logic                i_cmd_valid,
    input  wire logic [1:0]          i_cmd_op,
    input  wire logic [3:0]          i_cmd_len,
    input  wire logic [79:0]         i_cmd_args,
    input  wire logic                i_ack_enable,
    input  wire logic [NUM_PINS-1:0] i_iface_own,
    input  wire logic [NUM_PINS-1:0] i_pin_level,
    input  wire logic                i_net_rx_evt,
    input  wire logic                i_net_tx_evt,
    input  wire logic                i_ser_rx_evt,
    input  wire logic                i_ser_tx_evt,
    input  wire logic                i_power_on,
    output logic                     o_rsp_valid,
    output logic [7:0]               o_rsp_code,
    output logic                     o_rsp_has_field,
    output logic [7:0]               o_rsp_field,
    output logic [NUM_PINS-1:0]      o_pin_out,
    output logic [NUM_PINS-1:0]      o_pin_oe
);
    localparam int NI = glch_pkg::NUM_IND;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed
    {
        glch_pkg::glch_own_t [NUM_PINS-1:0] own;
        logic [NUM_PINS-1:0]                lvl;
        logic [NI-1:0][7:0]                 ind_pin;
        logic [NI-1:0]                      ind_en;
        logic                               rsp_valid;
        logic [7:0]                         rsp_code;
        logic                               rsp_has;
        logic [7:0]                         rsp_field;
    } glch_st_t;

    glch_st_t st_q;
    glch_st_t st_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] arg_byte(input logic [79:0] args, input int idx);
        arg_byte = args[idx*8 +: 8];
    endfunction : arg_byte

    function automatic logic pin_in_range(input logic [7:0] pin);
        pin_in_range = (32'(pin) < NUM_PINS);
    endfunction : pin_in_range

    function automatic logic [3:0] req_len(input logic [1:0] op);
        case (op)
            glch_pkg::CMD_LED_SETUP: req_len = glch_pkg::LEN_LED_SETUP;
            glch_pkg::CMD_PIN_SETUP: req_len = glch_pkg::LEN_PIN_SETUP;
            glch_pkg::CMD_PIN_WRITE: req_len = glch_pkg::LEN_PIN_WRITE;
            default:                 req_len = glch_pkg::LEN_PIN_READ;
        endcase
    endfunction : req_len

    // Interface claims override stored ownership
    function automatic glch_pkg::glch_own_t own_of(input glch_st_t s,
                                                    input logic [NUM_PINS-1:0] ifo,
                                                    input logic [7:0] pin);
        own_of = glch_pkg::OWN_UNUSED;
        if (pin_in_range(pin))
        begin
            if (ifo[pin[4:0]])
                own_of = glch_pkg::OWN_IFACE;
            else
                own_of = s.own[pin[4:0]];
        end
    endfunction : own_of

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    logic [7:0] a0;
    logic [7:0] a1;
    logic       dup_led;
    logic [7:0] err_code;
    logic [7:0] err_pin;
    logic       err_has;

    assign a0 = arg_byte(i_cmd_args, 0);
    assign a1 = arg_byte(i_cmd_args, 1);

    always_comb
    begin
        st_d           = st_q;
        st_d.rsp_valid = 1'b0;
        err_code       = glch_pkg::RSP_OK;
        err_pin        = 8'h00;
        err_has        = 1'b0;
        dup_led        = 1'b0;
        if (i_cmd_valid)
        begin
            // RL10 length check
            if (i_cmd_len < req_len(i_cmd_op))
                err_code = glch_pkg::RSP_SHORT;
            else if (i_cmd_len > req_len(i_cmd_op))
                err_code = glch_pkg::RSP_LONG;
            else
            begin
                // RL20 ownership consulted
                case (i_cmd_op)
                    glch_pkg::CMD_LED_SETUP:
                    begin
                        // RL1 five pin/config pairs
                        for (int i = 0; i < NI; i++)
                        begin
                            logic [7:0] p;
                            logic [7:0] c;
                            p = arg_byte(i_cmd_args, 2*i);
                            c = arg_byte(i_cmd_args, 2*i+1);
                            for (int j = 0; j < i; j++)
                                if (p != 8'h00 && p == arg_byte(i_cmd_args, 2*j))
                                    dup_led = 1'b1;
                            // RL2 zero pin disables
                            if (err_code == glch_pkg::RSP_OK && p != 8'h00)
                            begin
                                // RL6 not LED capable
                                if (!pin_in_range(p) || !LED_CAPABLE[p[4:0]])
                                begin
                                    err_code = glch_pkg::RSP_NOT_PIN;
                                    err_pin  = p;
                                    err_has  = 1'b1;
                                end
                                // RL4 RL7 must be unused
                                else if (own_of(st_q, i_iface_own, p) != glch_pkg::OWN_UNUSED
                                         || dup_led)
                                begin
                                    err_code = glch_pkg::RSP_IN_USE;
                                    err_pin  = p;
                                    err_has  = 1'b1;
                                end
                                // RL4 must be output
                                else if ((c & ~glch_pkg::CFG_VALID_MSK) != 8'h00
                                         || !c[glch_pkg::CFG_DIR_BIT])
                                    err_code = glch_pkg::RSP_BAD_CFG;
                            end
                        end
                        if (err_code == glch_pkg::RSP_OK)
                        begin
                            for (int i = 0; i < NI; i++)
                            begin
                                logic [7:0] p;
                                p = arg_byte(i_cmd_args, 2*i);
                                st_d.ind_en[i]  = (p != 8'h00);
                                st_d.ind_pin[i] = p;
                                // RL3 initial level ignored
                                if (p != 8'h00)
                                    st_d.own[p[4:0]] = glch_pkg::OWN_LED;
                            end
                        end
                    end
                    glch_pkg::CMD_PIN_SETUP:
                    begin
                        // RL12 not general-purpose
                        if (!pin_in_range(a0) || !GP_CAPABLE[a0[4:0]])
                        begin
                            err_code = glch_pkg::RSP_NOT_PIN;
                            err_pin  = a0;
                            err_has  = 1'b1;
                        end
                        // RL11 RL7 only unused pins
                        else if (own_of(st_q, i_iface_own, a0) != glch_pkg::OWN_UNUSED)
                        begin
                            err_code = glch_pkg::RSP_IN_USE;
                            err_pin  = a0;
                            err_has  = 1'b1;
                        end
                        // RL8 invalid configuration
                        else if ((a1 & ~glch_pkg::CFG_VALID_MSK) != 8'h00)
                            err_code = glch_pkg::RSP_BAD_CFG;
                        else
                        begin
                            st_d.own[a0[4:0]] = a1[glch_pkg::CFG_DIR_BIT]
                                ? glch_pkg::OWN_GP_OUT : glch_pkg::OWN_GP_IN;
                            st_d.lvl[a0[4:0]] = a1[glch_pkg::CFG_INIT_BIT];
                        end
                    end
                    glch_pkg::CMD_PIN_WRITE:
                    begin
                        // RL15 not general-purpose
                        if (!pin_in_range(a0) || !GP_CAPABLE[a0[4:0]])
                        begin
                            err_code = glch_pkg::RSP_NOT_PIN;
                            err_pin  = a0;
                            err_has  = 1'b1;
                        end
                        // RL14 only general outputs
                        else if (own_of(st_q, i_iface_own, a0) != glch_pkg::OWN_GP_OUT)
                        begin
                            err_code = glch_pkg::RSP_NOT_OUT;
                            err_pin  = a0;
                            err_has  = 1'b1;
                        end
                        // RL13 set output level
                        else
                            st_d.lvl[a0[4:0]] = a1[0];
                    end
                    default:
                    begin
                        // RL16 RL15 read checks
                        if (!pin_in_range(a0) || !GP_CAPABLE[a0[4:0]])
                        begin
                            err_code = glch_pkg::RSP_NOT_PIN;
                            err_pin  = a0;
                            err_has  = 1'b1;
                        end
                        // RL19 unused pin refused
                        else if (own_of(st_q, i_iface_own, a0) == glch_pkg::OWN_UNUSED)
                        begin
                            err_code = glch_pkg::RSP_UNCONF;
                            err_pin  = a0;
                            err_has  = 1'b1;
                        end
                        // RL17 RL18 return level
                        else
                        begin
                            err_pin = {7'h00, i_pin_level[a0[4:0]]};
                            err_has = 1'b1;
                        end
                    end
                endcase
            end
            // RL9 success only with acknowledges; pin reads always answer
            if (err_code != glch_pkg::RSP_OK || i_ack_enable
                || i_cmd_op == glch_pkg::CMD_PIN_READ)
            begin
                st_d.rsp_valid = 1'b1;
                st_d.rsp_code  = err_code;
                st_d.rsp_has   = err_has;
                st_d.rsp_field = err_pin;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    logic [NI-1:0] ind_evt;
    logic [NI-1:0] ind_led;

    // RL5 traffic and power sources
    assign ind_evt = {i_power_on, i_ser_tx_evt, i_ser_rx_evt, i_net_tx_evt, i_net_rx_evt};

    genvar g;
    generate
        for (g = 0; g < NI; g++)
        begin : g_ind
            glch_led_stretch #(
                .HOLD_CYC (HOLD_CYC)
            ) u_str (
                .i_clock  (i_clock),
                .i_rst_n  (i_rst_n),
                .i_enable (st_q.ind_en[g]),
                .i_event  (ind_evt[g]),
                .o_led    (ind_led[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    always_comb
    begin
        o_pin_out = '0;
        o_pin_oe  = '0;
        for (int k = 0; k < NUM_PINS; k++)
        begin
            if (!i_iface_own[k] && st_q.own[k] == glch_pkg::OWN_GP_OUT)
            begin
                o_pin_out[k] = st_q.lvl[k];
                o_pin_oe[k]  = 1'b1;
            end
        end
        for (int i = 0; i < NI; i++)
        begin
            if (st_q.ind_en[i] && pin_in_range(st_q.ind_pin[i]))
            begin
                o_pin_out[st_q.ind_pin[i][4:0]] = ind_led[i];
                o_pin_oe[st_q.ind_pin[i][4:0]]  = 1'b1;
            end
        end
    end

    assign o_rsp_valid     = st_q.rsp_valid;
    assign o_rsp_code      = st_q.rsp_code;
    assign o_rsp_has_field = st_q.rsp_has;
    assign o_rsp_field     = st_q.rsp_field;
endmodule : glch_cmd_handler

// ---- test/glch_cmd_sva.sv ----
// Checker for the pin and indicator command handler.
// Assumes binding onto the handler's ports.
`timescale 1ns/100ps
module glch_cmd_sva #(
    parameter int NUM_PINS = 32
) (
    input wire logic                i_clock,
    input wire logic                i_rst_n,
    input wire logic                i_cmd_valid,
    input wire logic [1:0]          i_cmd_op,
    input wire logic [3:0]          i_cmd_len,
    input wire logic [79:0]         i_cmd_args,
    input wire logic                i_ack_enable,
    input wire logic [NUM_PINS-1:0] i_pin_level,
    input wire logic                o_rsp_valid,
    input wire logic [7:0]          o_rsp_code,
    input wire logic                o_rsp_has_field,
    input wire logic [7:0]          o_rsp_field,
    input wire logic [NUM_PINS-1:0] o_pin_out,
    input wire logic [NUM_PINS-1:0] o_pin_oe
);
    logic [1:0] op_q;
    logic [7:0] pin_q;
    logic       val_q;
    logic       lvl_q;
    wire logic [3:0] req_len = (i_cmd_op == glch_pkg::CMD_LED_SETUP) ? glch_pkg::LEN_LED_SETUP
        : (i_cmd_op == glch_pkg::CMD_PIN_READ) ? glch_pkg::LEN_PIN_READ
        : glch_pkg::LEN_PIN_SETUP;

    // Previous command, beside its response
    always_ff @(posedge i_clock)
    begin
        op_q  <= i_cmd_op;
        pin_q <= i_cmd_args[7:0];
        val_q <= i_cmd_args[8];
        lvl_q <= i_pin_level[i_cmd_args[4:0]];
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    rsp_has_cause_a: assert property (o_rsp_valid |-> $past(i_cmd_valid))
        else $error("stray response");
    short_frame_a: assert property (i_cmd_valid && i_cmd_len < req_len
        |=> o_rsp_valid && o_rsp_code == glch_pkg::RSP_SHORT) else $error("short code");
    long_frame_a: assert property (i_cmd_valid && i_cmd_len > req_len
        |=> o_rsp_valid && o_rsp_code == glch_pkg::RSP_LONG) else $error("long code");
    read_answered_a: assert property (i_cmd_valid && i_cmd_op == glch_pkg::CMD_PIN_READ
        |=> o_rsp_valid) else $error("read silent");
    read_level_a: assert property (o_rsp_valid && op_q == glch_pkg::CMD_PIN_READ
        && o_rsp_code == glch_pkg::RSP_OK |-> o_rsp_has_field && o_rsp_field == {7'h00, lvl_q})
        else $error("read level");
    error_pin_field_a: assert property (o_rsp_valid && op_q != glch_pkg::CMD_LED_SETUP
        && o_rsp_code inside {8'h08, 8'h09, 8'h16, 8'h17}
        |-> o_rsp_has_field && o_rsp_field == pin_q) else $error("error pin");
    silent_success_a: assert property (i_cmd_valid && !i_ack_enable
        && i_cmd_op != glch_pkg::CMD_PIN_READ |=> !(o_rsp_valid && o_rsp_code == 8'h00))
        else $error("silent success sent");
    write_effect_a: assert property (o_rsp_valid && op_q == glch_pkg::CMD_PIN_WRITE
        && o_rsp_code == glch_pkg::RSP_OK |-> o_pin_oe[pin_q[4:0]] && o_pin_out[pin_q[4:0]] == val_q)
        else $error("write not on pin");
endmodule : glch_cmd_sva

bind glch_cmd_handler glch_cmd_sva #(.NUM_PINS(NUM_PINS)) u_sva (.*);

// ---- test/glch_host_model.sv ----
// Host side of the command link: offers one parsed frame per request.
// Assumes the bench changes the request inputs just after a falling edge.
`timescale 1ns/100ps
module glch_host_model (
    input  wire logic        i_send,
    input  wire logic [1:0]  i_op,
    input  wire logic [3:0]  i_len,
    input  wire logic [79:0] i_args,
    output logic             o_cmd_valid,
    output logic [1:0]       o_cmd_op,
    output logic [3:0]       o_cmd_len,
    output logic [79:0]      o_cmd_args
);
    assign o_cmd_valid = i_send;
    assign o_cmd_op    = i_op;
    assign o_cmd_len   = i_len;
    assign o_cmd_args  = i_args;
endmodule : glch_host_model

// ---- test/testbench.sv ----
// Self-checking bench for the pin and indicator command handler.
// Assumes a short indicator hold so blinks can be timed.
`timescale 1ns/100ps
module testbench;
    localparam int HOLD = 4;
    logic        i_clock, i_rst_n, send, ack, pwr, cv, rv, hf;
    logic [1:0]  op, cop;
    logic [3:0]  len, clen, evt;
    logic [79:0] args, cargs;
    logic [31:0] lvl, iface, pin_out, pin_oe;
    logic [7:0]  rc, rf;
    int          own[32], outv[32];
    int          n_mismatch, checks;

    glch_host_model host (.i_send(send), .i_op(op), .i_len(len),
        .i_args(args), .o_cmd_valid(cv), .o_cmd_op(cop), .o_cmd_len(clen), .o_cmd_args(cargs));
    glch_cmd_handler #(.NUM_PINS(32), .HOLD_CYC(HOLD)) uut (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_cmd_valid(cv), .i_cmd_op(cop), .i_cmd_len(clen),
        .i_cmd_args(cargs), .i_ack_enable(ack), .i_iface_own(iface), .i_pin_level(lvl),
        .i_net_rx_evt(evt[0]), .i_net_tx_evt(evt[1]), .i_ser_rx_evt(evt[2]),
        .i_ser_tx_evt(evt[3]), .i_power_on(pwr), .o_rsp_valid(rv), .o_rsp_code(rc),
        .o_rsp_has_field(hf), .o_rsp_field(rf), .o_pin_out(pin_out), .o_pin_oe(pin_oe));

    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    function automatic int need(input logic [1:0] o);
        return (o == glch_pkg::CMD_LED_SETUP) ? 10 : (o == glch_pkg::CMD_PIN_READ) ? 1 : 2;
    endfunction : need

    // Code -1 means silent, field -1 means none
    task automatic model(output int c, output int f);
        int p, g, k, q;
        c = 0;
        f = -1;
        p = args[7:0];
        g = args[15:8];
        if (len < need(op)) c = 1;
        else if (len > need(op)) c = 2;
        else if (op == glch_pkg::CMD_LED_SETUP)
        begin
            for (k = 0; k < 5 && c == 0; k++)
            begin
                p = args[16*k +: 8];
                g = args[16*k+8 +: 8];
                if (p == 0) continue;
                if (p > 31) c = 8;
                else if (own[p] != 0 || iface[p]) c = 9;
                for (q = 0; q < k; q++)
                    if (c == 0 && args[16*q +: 8] == p) c = 9;
                if (c == 0 && (g[0] == 0 || g > 3)) c = 18;
            end
            for (k = 0; k < 5 && c == 0; k++)
                if (args[16*k +: 8] != 0) own[args[16*k +: 8]] = 3;
        end
        else if (p == 0 || p > 31) c = 8;
        else if (op == glch_pkg::CMD_PIN_SETUP)
        begin
            if (own[p] != 0 || iface[p]) c = 9;
            else if (g > 3) c = 18;
            else
            begin
                own[p] = g[0] ? 2 : 1;
                outv[p] = g[1];
            end
        end
        else if (op == glch_pkg::CMD_PIN_WRITE)
        begin
            if (own[p] != 2) c = 22;
            else outv[p] = g[0];
        end
        else if (own[p] == 0 && !iface[p]) c = 23;
        else f = lvl[p];
        if (c inside {8, 9, 22, 23}) f = p;
        if (c == 0 && op != glch_pkg::CMD_PIN_READ && !ack) c = -1;
    endtask : model

    task automatic cmd(input logic [1:0] o, input logic [3:0] n, input logic [79:0] a);
        int c, f, p;
        op = o;
        len = n;
        args = a;
        lvl = $urandom;
        send = 1'b1;
        model(c, f);
        @(negedge i_clock);
        send = 1'b0;
        cmp(rv, c >= 0);
        if (c >= 0)
        begin
            cmp(rc, c);
            cmp({hf, rf}, f < 0 ? 0 : 9'h100 | f);
        end
        for (p = 1; p < 32; p++)
            cmp({pin_oe[p], own[p] == 2 && pin_out[p]}, {own[p] >= 2, own[p] == 2 && outv[p][0]});
        @(negedge i_clock);
    endtask : cmd

    task automatic blink(input int e, input int p, input bit en);
        int n;
        n = 0;
        evt[e] = 1'b1;
        @(negedge i_clock);
        evt[e] = 1'b0;
        repeat (HOLD + 4)
        begin
            n += pin_out[p];
            @(negedge i_clock);
        end
        cmp(en ? (n >= HOLD && n <= HOLD + 2) : (n == 0), 1);
    endtask : blink

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        int b;
        {i_rst_n, send, pwr, evt, op, len, args, lvl} = '0;
        ack = 1'b1;
        iface = 32'hc000_0000;
        void'($urandom(21141));
        repeat (12) @(negedge i_clock);
        i_rst_n = 1'b1;
        for (int o = 0; o < 4; o++)
        begin
            cmd(2'(o), 4'(need(2'(o)) - 1), '0);
            cmd(2'(o), 4'(need(2'(o)) + 1), '0);
        end
        $display("lengths done");
        cmd(glch_pkg::CMD_PIN_SETUP, 2, {8'h01, 8'h00});
        cmd(glch_pkg::CMD_PIN_SETUP, 2, {8'h04, 8'h03});
        cmd(glch_pkg::CMD_PIN_SETUP, 2, {8'h03, 8'h03});
        cmd(glch_pkg::CMD_PIN_SETUP, 2, {8'h00, 8'h03});
        cmd(glch_pkg::CMD_PIN_SETUP, 2, {8'h00, 8'h04});
        cmd(glch_pkg::CMD_PIN_SETUP, 2, {8'h01, 8'h1e});
        cmd(glch_pkg::CMD_PIN_WRITE, 2, {8'h00, 8'h03});
        cmd(glch_pkg::CMD_PIN_WRITE, 2, {8'h01, 8'h04});
        cmd(glch_pkg::CMD_PIN_WRITE, 2, {8'h01, 8'h09});
        cmd(glch_pkg::CMD_PIN_WRITE, 2, {8'h01, 8'h28});
        cmd(glch_pkg::CMD_PIN_READ, 1, 8'h04);
        cmd(glch_pkg::CMD_PIN_READ, 1, 8'h09);
        cmd(glch_pkg::CMD_PIN_READ, 1, 8'h1f);
        cmd(glch_pkg::CMD_PIN_READ, 1, 8'h00);
        ack = 1'b0;
        cmd(glch_pkg::CMD_PIN_WRITE, 2, {8'h01, 8'h03});
        cmd(glch_pkg::CMD_PIN_READ, 1, 8'h03);
        ack = 1'b1;
        $display("pins done");
        cmd(glch_pkg::CMD_LED_SETUP, 10, {8'h01, 8'h04, 8'h01, 8'h05});
        cmd(glch_pkg::CMD_LED_SETUP, 10, {8'h00, 8'h08, 8'h01, 8'h05});
        cmd(glch_pkg::CMD_LED_SETUP, 10, {8'h01, 8'h28});
        cmd(glch_pkg::CMD_LED_SETUP, 10,
            {8'h01, 8'h07, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h00, 8'h01, 8'h05});
        cmd(glch_pkg::CMD_PIN_READ, 1, 8'h05);
        $display("indicator setup done");
        blink(0, 5, 1);
        blink(2, 6, 1);
        blink(1, 5, 0);
        blink(3, 6, 0);
        blink(2, 5, 0);
        pwr = 1'b1;
        repeat (HOLD + 4) @(negedge i_clock);
        cmp(pin_out[7], 1);
        pwr = 1'b0;
        repeat (HOLD + 3) @(negedge i_clock);
        cmp(pin_out[7], 0);
        $display("indicators done");
        repeat (80)
        begin
            ack = 1'($urandom);
            op = 2'($urandom_range(1, 3));
            b = $urandom_range(0, op == glch_pkg::CMD_PIN_WRITE ? 1 : 3);
            cmd(op, 4'(need(op)), {8'(b), 8'($urandom_range(0, 33))});
        end
        $display("random done");
        report_and_stop();
    end
endmodule : testbench
